// *** scm_synth_config.sv ***
// Purpose: loop options and extended fraction words of a dual synthesizer
// Assumes: serial pins synchronous to clk_sys; other words decoded elsewhere
// Notes:   every latched word is also passed out for the other word banks
// Function
// [RULE1] select codes 0..2 give hi-z, constant high, constant low on test pin
// [RULE2] codes 3..5 drive combined, main, aux digital lock push-pull
// [RULE3] codes 6..8 analog lock open drain, codes 9..11 same push-pull
// [RULE4] codes 12..15 drive halved aux ref, aux fb, main ref, main fb
// [RULE5] prescaler bit picks 8/9 at zero, 16/17 at one
// [RULE6] main pump polarity: zero negative, one positive, positive after reset
// [RULE7] aux polarity: one positive, zero negative; host normally writes one
// [RULE8] reference buffer bit off floats output, on copies reference input
// [RULE9] doubler bit doubles only the main reference counter feed
// [RULE10] order field: 0 fourth, 1 bypass, 2 second, 3 third order
// [RULE11] dither field: 0 off, 1 weak, 2 strong, 3 reserved
// [RULE12] auto power-up set: any word zero write clears both power-downs
// [RULE13] chip enable low blocks auto power-up, power-downs untouched
// [RULE14] narrow mode ignores upper fraction bits, wide mode joins 22 bits
// [RULE15] upper numerator bits have no effect in narrow mode
// [RULE16] host writes upper numerator zero when numerator is below 4096
// [RULE17] access field in word three marks which optional words are used
// [RULE18] unmarked optional word is forced to its default contents
// [RULE19] words are routed by four low address bits; extended word 1011
// [RULE20] settings change only after a whole word has been latched
`timescale 1ns/1ps
`default_nettype none
`include "scm_params.svh"
module scm_synth_config #(
	parameter int WordW = `SCM_WORD_W,
	parameter int FracW = `SCM_FRAC_W
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             serClk,
	input  wire logic             serData,
	input  wire logic             serLatch,
	input  wire logic             chipEnable,
	input  wire logic             pdLoad,
	input  wire logic             pdMainIn,
	input  wire logic             pdAuxIn,
	input  wire logic             mainDigLock,
	input  wire logic             auxDigLock,
	input  wire logic             mainAnaLock,
	input  wire logic             auxAnaLock,
	input  wire logic             auxRefDiv,
	input  wire logic             auxFbDiv,
	input  wire logic             mainRefDiv,
	input  wire logic             mainFbDiv,
	input  wire logic             refInputPin,
	input  wire logic [11:0]      fracNumLow,
	input  wire logic [11:0]      fracDenLow,
	output logic                  testLockOut,
	output logic                  testLockOe,
	output logic                  refOutPin,
	output logic                  refOutOe,
	output logic                  auxPrescaler16,
	output logic                  mainPumpPositive,
	output logic                  auxPumpPositive,
	output logic                  mainRefDoubler,
	output logic [1:0]            modulatorOrder,
	output logic                  modulatorBypass,
	output logic                  ditherWeak,
	output logic                  ditherStrong,
	output logic                  mainPowerdown,
	output logic                  auxPowerdown,
	output logic                  fracWide,
	output logic [FracW-1:0]      fracNumerator,
	output logic [FracW-1:0]      fracDenominator,
	output logic [WordW-1:0]      wordData,
	output logic [3:0]            wordAddr,
	output logic                  wordStrobe,
	output logic [3:0]            accessBits
);
	logic [WordW-1:0]        loopQ;
	logic [WordW-1:0]        extQ;
	logic [3:0]              accessQ;
	logic                    mainPdQ;
	logic                    auxPdQ;
	logic                    fracWideQ;
	logic [FracW-1:0]        fracNumQ;
	logic [FracW-1:0]        fracDenQ;
	logic                    refOutQ;
	logic                    autoPowerup;
	logic                    word0Write;
	scm_pkg::scm_modorder_t  modOrder;
	scm_pkg::scm_dither_t    dither;

	// address of a latched word
	function automatic logic [3:0] addrOf(input logic [WordW-1:0] w);
		addrOf = w[`SCM_ADDR_W-1:0];
	endfunction : addrOf

	// word zero carries a one-bit address, so only its low bit is compared
	function automatic logic isWord0(input logic [3:0] a);
		isWord0 = ((a & `SCM_WORD0_MASK) == `SCM_WORD0_CODE);
	endfunction : isWord0

	scm_serial_rx #(
		.WordW      (WordW)
	) u_rx (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.serClk     (serClk),
		.serData    (serData),
		.serLatch   (serLatch),
		.wordData   (wordData),
		.wordStrobe (wordStrobe)
	);

	assign wordAddr   = addrOf(wordData);
	assign accessBits = accessQ;

	// access field of word three; the enable bit for word zero is kept as written
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			accessQ <= `SCM_RST_ACCESS;
		end else if (wordStrobe && (wordAddr == `SCM_ADDR_ACCESS)) begin
			accessQ <= wordData[`SCM_ACCESS_LSB +: 4]; // see [RULE17] [RULE19]
		end
	end

	// loop options word, updated only on a completed word
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			loopQ <= `SCM_RST_LOOP;
		end else if (wordStrobe && (wordAddr == `SCM_ADDR_LOOP)) begin
			loopQ <= wordData; // see [RULE19] [RULE20]
		end
	end

	// extended fraction word; held at default while its access bit is clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			extQ <= `SCM_RST_EXT;
		end else if (!accessQ[`SCM_ACCESS_EXT]) begin
			extQ <= `SCM_RST_EXT; // see [RULE18]
		end else if (wordStrobe && (wordAddr == `SCM_ADDR_EXT)) begin
			extQ <= wordData; // see [RULE19] [RULE20]
		end
	end

	// field decode of the loop options word
	assign autoPowerup      = loopQ[`SCM_AUTOPU_BIT];
	assign auxPrescaler16   = loopQ[`SCM_PRESC_BIT]; // see [RULE5]
	assign mainPumpPositive = loopQ[`SCM_MAINPOL_BIT]; // see [RULE6]
	assign auxPumpPositive  = loopQ[`SCM_AUXPOL_BIT]; // see [RULE7]
	assign mainRefDoubler   = loopQ[`SCM_DBL_BIT]; // see [RULE9]
	assign modOrder         = scm_pkg::scm_modorder_t'(loopQ[`SCM_MOD_LSB +: 2]);
	assign modulatorOrder   = modOrder; // see [RULE10]
	assign modulatorBypass  = (modOrder == scm_pkg::SCM_MOD_BYPASS); // see [RULE10]
	assign dither           = scm_pkg::scm_dither_t'(loopQ[`SCM_DITHER_SELECT_LSB +: 2]);
	// reserved dither code falls back to no dithering rather than a guess
	assign ditherWeak       = (dither == scm_pkg::SCM_DITHER_SELECT_WEAK); // see [RULE11]
	assign ditherStrong     = (dither == scm_pkg::SCM_DITHER_SELECT_STRONG); // see [RULE11]

	scm_lock_mux u_mux (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.outSelect   (loopQ[`SCM_OSEL_LSB +: 4]),
		.mainDigLock (mainDigLock),
		.auxDigLock  (auxDigLock),
		.mainAnaLock (mainAnaLock),
		.auxAnaLock  (auxAnaLock),
		.divIn       ({mainFbDiv, mainRefDiv, auxFbDiv, auxRefDiv}),
		.pinOut      (testLockOut),
		.pinOe       (testLockOe)
	);

	// reference buffer copies the input one cycle late, quiet when disabled
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			refOutQ <= 1'b0;
		end else begin
			refOutQ <= refInputPin && loopQ[`SCM_REFBUF_BIT]; // see [RULE8]
		end
	end
	assign refOutPin = refOutQ;
	assign refOutOe  = loopQ[`SCM_REFBUF_BIT]; // see [RULE8]

	// auto power-up on word zero beats a simultaneous power-down load
	assign word0Write = wordStrobe && isWord0(wordAddr);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mainPdQ <= `SCM_RST_PD;
			auxPdQ  <= `SCM_RST_PD;
		end else if (word0Write && autoPowerup && chipEnable) begin
			mainPdQ <= 1'b0; // see [RULE12] [RULE13]
			auxPdQ  <= 1'b0; // see [RULE12]
		end else if (pdLoad) begin
			mainPdQ <= pdMainIn;
			auxPdQ  <= pdAuxIn;
		end
	end
	assign mainPowerdown = mainPdQ;
	assign auxPowerdown  = auxPdQ;

	// upper fraction bits only count in wide mode; host keeps them zero below 4096
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fracWideQ <= 1'b0;
			fracNumQ  <= '0;
			fracDenQ  <= '0;
		end else begin
			fracWideQ <= accessQ[`SCM_ACCESS_EXT]; // see [RULE14]
			fracNumQ  <= {accessQ[`SCM_ACCESS_EXT] ? extQ[`SCM_EXTNUM_LSB +: `SCM_EXT_W] : 10'h000,
				fracNumLow}; // see [RULE14] [RULE15] [RULE16]
			fracDenQ  <= {accessQ[`SCM_ACCESS_EXT] ? extQ[`SCM_EXTDEN_LSB +: `SCM_EXT_W] : 10'h000,
				fracDenLow}; // see [RULE14]
		end
	end
	assign fracWide        = fracWideQ;
	assign fracNumerator   = fracNumQ;
	assign fracDenominator = fracDenQ;

	property p_loopStable;
		@(posedge clk_sys) disable iff (rst)
		!wordStrobe |=> $stable(loopQ) && ($stable(extQ) || !accessQ[`SCM_ACCESS_EXT]);
	endproperty
	a_loopStable: assert property (p_loopStable) else $error("config moved without a word"); // see [RULE20]

	property p_loopLoad;
		@(posedge clk_sys) disable iff (rst)
		(wordStrobe && (wordAddr == `SCM_ADDR_LOOP)) |=> (loopQ == $past(wordData));
	endproperty
	a_loopLoad: assert property (p_loopLoad) else $error("loop word not latched"); // see [RULE19]

	property p_prescLoad;
		@(posedge clk_sys) disable iff (rst)
		(wordStrobe && (wordAddr == `SCM_ADDR_LOOP))
		|=> (auxPrescaler16 == $past(wordData[`SCM_PRESC_BIT]))
		&& (mainPumpPositive == $past(wordData[`SCM_MAINPOL_BIT]));
	endproperty
	a_prescLoad: assert property (p_prescLoad) else $error("prescaler or polarity wrong"); // see [RULE5] [RULE6]

	property p_bypassLoad;
		@(posedge clk_sys) disable iff (rst)
		(wordStrobe && (wordAddr == `SCM_ADDR_LOOP))
		|=> (modulatorBypass == ($past(wordData[`SCM_MOD_LSB +: 2]) == 2'h1));
	endproperty
	a_bypassLoad: assert property (p_bypassLoad) else $error("modulator bypass wrong"); // see [RULE10]

	property p_refCopy;
		@(posedge clk_sys) disable iff (rst)
		(loopQ[`SCM_REFBUF_BIT] && $stable(loopQ)) |-> refOutOe && (refOutPin == $past(refInputPin));
	endproperty
	a_refCopy: assert property (p_refCopy) else $error("reference copy wrong"); // see [RULE8]

	property p_autoPowerup;
		@(posedge clk_sys) disable iff (rst)
		(word0Write && autoPowerup && chipEnable) |=> !mainPowerdown && !auxPowerdown;
	endproperty
	a_autoPowerup: assert property (p_autoPowerup) else $error("auto power-up missed"); // see [RULE12]

	property p_ceBlocks;
		@(posedge clk_sys) disable iff (rst)
		(word0Write && !chipEnable && !pdLoad) |=> $stable(mainPowerdown) && $stable(auxPowerdown);
	endproperty
	a_ceBlocks: assert property (p_ceBlocks) else $error("power-down moved with chip disabled"); // see [RULE13]

	property p_narrowFrac;
		@(posedge clk_sys) disable iff (rst)
		!fracWide |-> (fracNumerator[FracW-1:12] == 10'h000) && (fracDenominator[FracW-1:12] == 10'h000);
	endproperty
	a_narrowFrac: assert property (p_narrowFrac) else $error("upper fraction used in narrow mode"); // see [RULE14] [RULE15]

	property p_extDefault;
		@(posedge clk_sys) disable iff (rst)
		!accessQ[`SCM_ACCESS_EXT] |=> (extQ == `SCM_RST_EXT);
	endproperty
	a_extDefault: assert property (p_extDefault) else $error("optional word not at default"); // see [RULE18]
endmodule : scm_synth_config
`default_nettype wire

// *** scm_params.svh ***
// Purpose: constants for the synthesizer configuration bank
// Assumes: 24-bit serial words, address in the four low bits
// Notes:   field positions are bit indices inside a serial word
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH
`define SCM_WORD_W        24
`define SCM_ADDR_W        4
`define SCM_FRAC_W        22
`define SCM_FRAC_LOW_W    12
`define SCM_EXT_W         10
`define SCM_ADDR_ACCESS   4'h7
`define SCM_ADDR_LOOP     4'h9
`define SCM_ADDR_EXT      4'hb
`define SCM_WORD0_MASK    4'h1
`define SCM_WORD0_CODE    4'h0
`define SCM_AUTOPU_BIT    23
`define SCM_DITHER_SELECT_LSB      16
`define SCM_MOD_LSB       14
`define SCM_DBL_BIT       12
`define SCM_REFBUF_BIT    11
`define SCM_AUXPOL_BIT    10
`define SCM_MAINPOL_BIT   9
`define SCM_PRESC_BIT     8
`define SCM_OSEL_LSB      4
`define SCM_EXTDEN_LSB    14
`define SCM_EXTNUM_LSB    4
`define SCM_ACCESS_LSB    20
`define SCM_ACCESS_EXT    1
`define SCM_RST_LOOP      24'h22c709
`define SCM_RST_EXT       24'h00000b
`define SCM_RST_ACCESS    4'h1
`define SCM_RST_PD        1'b1
`endif

// *** scm_pkg.sv ***
// Purpose: shared types of the synthesizer configuration bank
// Assumes: codes match the four-bit and two-bit word fields
// Notes:   constants live in scm_params.svh
`default_nettype none
package scm_pkg;
	typedef enum logic [3:0] {
		SCM_SEL_HIZ      = 4'h0, SCM_SEL_HIGH     = 4'h1, SCM_SEL_LOW      = 4'h2,
		SCM_SEL_DIG_BOTH = 4'h3, SCM_SEL_DIG_MAIN = 4'h4, SCM_SEL_DIG_AUX  = 4'h5,
		SCM_SEL_OD_BOTH  = 4'h6, SCM_SEL_OD_MAIN  = 4'h7, SCM_SEL_OD_AUX   = 4'h8,
		SCM_SEL_PP_BOTH  = 4'h9, SCM_SEL_PP_MAIN  = 4'ha, SCM_SEL_PP_AUX   = 4'hb,
		SCM_SEL_AUX_REF  = 4'hc, SCM_SEL_AUX_FB   = 4'hd, SCM_SEL_MAIN_REF = 4'he,
		SCM_SEL_MAIN_FB  = 4'hf
	} scm_outsel_t;
	typedef enum logic [1:0] {
		SCM_MOD_4TH    = 2'h0,
		SCM_MOD_BYPASS = 2'h1,
		SCM_MOD_2ND    = 2'h2,
		SCM_MOD_3RD    = 2'h3
	} scm_modorder_t;
	typedef enum logic [1:0] {
		SCM_DITHER_SELECT_OFF    = 2'h0,
		SCM_DITHER_SELECT_WEAK   = 2'h1,
		SCM_DITHER_SELECT_STRONG = 2'h2,
		SCM_DITHER_SELECT_RSVD   = 2'h3
	} scm_dither_t;
endpackage : scm_pkg
`default_nettype wire

// *** scm_serial_rx.sv ***
// Purpose: three-wire serial word receiver
// Assumes: serial pins already synchronous to clk_sys, msb first
// Notes:   word is handed on only at the rising edge of the latch line
`timescale 1ns/1ps
`default_nettype none
`include "scm_params.svh"
module scm_serial_rx #(
	parameter int WordW = `SCM_WORD_W
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             serClk,
	input  wire logic             serData,
	input  wire logic             serLatch,
	output logic [WordW-1:0]      wordData,
	output logic                  wordStrobe
);
	logic [WordW-1:0] shiftQ;
	logic             clkPrevQ;
	logic             latchPrevQ;

	// edge history of the serial clock and latch lines
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clkPrevQ   <= 1'b0;
			latchPrevQ <= 1'b0;
		end else begin
			clkPrevQ   <= serClk;
			latchPrevQ <= serLatch;
		end
	end

	// shift one bit in per rising serial clock edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shiftQ <= '0;
		end else if (serClk && !clkPrevQ) begin
			shiftQ <= {shiftQ[WordW-2:0], serData};
		end
	end

	// hand the whole word on only at latch, never mid-shift
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wordData   <= '0;
			wordStrobe <= 1'b0;
		end else begin
			wordStrobe <= serLatch && !latchPrevQ; // see [RULE20]
			if (serLatch && !latchPrevQ) begin
				wordData <= shiftQ; // see [RULE20]
			end
		end
	end
endmodule : scm_serial_rx
`default_nettype wire

// *** scm_lock_mux.sv ***
// Purpose: test and lock-detect output pin selector
// Assumes: lock and divider inputs synchronous to clk_sys
// Notes:   pin output and enable are registered, one cycle behind select
`timescale 1ns/1ps
`default_nettype none
module scm_lock_mux (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [3:0] outSelect,
	input  wire logic       mainDigLock,
	input  wire logic       auxDigLock,
	input  wire logic       mainAnaLock,
	input  wire logic       auxAnaLock,
	input  wire logic [3:0] divIn,
	output logic            pinOut,
	output logic            pinOe
);
	scm_pkg::scm_outsel_t sel;
	logic [3:0] divPrevQ;
	logic [3:0] halfQ;
	logic       driveD;
	logic       oeD;

	assign sel = scm_pkg::scm_outsel_t'(outSelect);

	// halve each divider output by toggling on its rising edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			divPrevQ <= 4'h0;
			halfQ    <= 4'h0;
		end else begin
			divPrevQ <= divIn;
			halfQ    <= halfQ ^ (divIn & ~divPrevQ); // see [RULE4]
		end
	end

	// open drain pulls low only, so the enable follows the inverse level
	always_comb begin
		driveD = 1'b0;
		oeD    = 1'b1;
		unique case (sel)
			scm_pkg::SCM_SEL_HIZ:      oeD = 1'b0; // see [RULE1]
			scm_pkg::SCM_SEL_HIGH:     driveD = 1'b1; // see [RULE1]
			scm_pkg::SCM_SEL_LOW:      driveD = 1'b0; // see [RULE1]
			scm_pkg::SCM_SEL_DIG_BOTH: driveD = mainDigLock && auxDigLock; // see [RULE2]
			scm_pkg::SCM_SEL_DIG_MAIN: driveD = mainDigLock; // see [RULE2]
			scm_pkg::SCM_SEL_DIG_AUX:  driveD = auxDigLock; // see [RULE2]
			scm_pkg::SCM_SEL_OD_BOTH:  oeD = !(mainAnaLock && auxAnaLock); // see [RULE3]
			scm_pkg::SCM_SEL_OD_MAIN:  oeD = !mainAnaLock; // see [RULE3]
			scm_pkg::SCM_SEL_OD_AUX:   oeD = !auxAnaLock; // see [RULE3]
			scm_pkg::SCM_SEL_PP_BOTH:  driveD = mainAnaLock && auxAnaLock; // see [RULE3]
			scm_pkg::SCM_SEL_PP_MAIN:  driveD = mainAnaLock; // see [RULE3]
			scm_pkg::SCM_SEL_PP_AUX:   driveD = auxAnaLock; // see [RULE3]
			scm_pkg::SCM_SEL_AUX_REF:  driveD = halfQ[0]; // see [RULE4]
			scm_pkg::SCM_SEL_AUX_FB:   driveD = halfQ[1]; // see [RULE4]
			scm_pkg::SCM_SEL_MAIN_REF: driveD = halfQ[2]; // see [RULE4]
			scm_pkg::SCM_SEL_MAIN_FB:  driveD = halfQ[3]; // see [RULE4]
		endcase
	end

	// registered pin drive, released at reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pinOut <= 1'b0;
			pinOe  <= 1'b0;
		end else begin
			pinOut <= driveD;
			pinOe  <= oeD;
		end
	end

	property p_hizSel;
		@(posedge clk_sys) disable iff (rst)
		(sel == scm_pkg::SCM_SEL_HIZ) |=> !pinOe;
	endproperty
	a_hizSel: assert property (p_hizSel) else $error("pin driven in hi-z select"); // see [RULE1]

	property p_digBoth;
		@(posedge clk_sys) disable iff (rst)
		(sel == scm_pkg::SCM_SEL_DIG_BOTH) |=> pinOe && (pinOut == $past(mainDigLock && auxDigLock));
	endproperty
	a_digBoth: assert property (p_digBoth) else $error("combined digital lock wrong"); // see [RULE2]

	property p_odMain;
		@(posedge clk_sys) disable iff (rst)
		(sel == scm_pkg::SCM_SEL_OD_MAIN) |=> !pinOut && (pinOe == !$past(mainAnaLock));
	endproperty
	a_odMain: assert property (p_odMain) else $error("open drain lock wrong"); // see [RULE3]

	property p_mainFbHalf;
		@(posedge clk_sys) disable iff (rst)
		(sel == scm_pkg::SCM_SEL_MAIN_FB) |=> pinOe && (pinOut == $past(halfQ[3]));
	endproperty
	a_mainFbHalf: assert property (p_mainFbHalf) else $error("halved divider not shown"); // see [RULE4]
endmodule : scm_lock_mux
`default_nettype wire

// *** scm_host_model.sv ***
// Purpose: host side of the three-wire serial programming port
// Assumes: words go out msb first, address in the four low bits
// Notes:   data line shows the inverse of its last bit between frames
`timescale 1ns/1ps
`default_nettype none
module scm_host_model (
	input  wire logic clk_sys,
	output logic      serClk,
	output logic      serData,
	output logic      serLatch
);
	initial begin
		serClk = 1'b0;
		serData = 1'b0;
		serLatch = 1'b0;
	end
	// one low and one high cycle per bit; slow stretches the low phase
	task automatic shift(input logic [23:0] w, input int slow);
		for (int i = 23; i >= 0; i--) begin
			@(negedge clk_sys);
			serClk = 1'b0;
			serData = w[i];
			repeat (slow) @(negedge clk_sys);
			@(negedge clk_sys);
			serClk = 1'b1;
		end
		@(negedge clk_sys);
		serClk = 1'b0;
		serData = ~w[0]; // released line must not look like held data
	endtask : shift
	// latch rises two cycles after the last rising shift edge
	task automatic latch();
		@(negedge clk_sys);
		serLatch = 1'b1;
		@(negedge clk_sys);
		serLatch = 1'b0;
	endtask : latch
endmodule : scm_host_model
`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench of the synthesizer configuration bank
// Assumes: inputs change on the falling edge, seed fixed at 8
// Notes:   expectations come from word fields, never from outputs
`timescale 1ns/1ps
`default_nettype none
`include "scm_params.svh"
module tb;
	logic        clk_sys, rst, serClk, serData, serLatch, chipEnable, pdLoad, pdMainIn, pdAuxIn, refInputPin;
	logic        testLockOut, testLockOe, refOutPin, refOutOe, auxPrescaler16, mainPumpPositive, auxPumpPositive;
	logic        mainRefDoubler, modulatorBypass, ditherWeak, ditherStrong, mainPowerdown, auxPowerdown;
	logic        fracWide, wordStrobe, prev;
	logic [1:0]  modulatorOrder;
	logic [3:0]  locks, wordAddr, accessBits;
	logic [7:0]  divCnt;
	logic [9:0]  nu, du;
	logic [11:0] fracNumLow, fracDenLow;
	logic [21:0] fracNumerator, fracDenominator;
	logic [23:0] wordData, w, cur;
	int          n_errors, check_count, n, e;

	scm_host_model host (.clk_sys, .serClk, .serData, .serLatch);
	scm_synth_config uut (.clk_sys, .rst, .serClk, .serData, .serLatch, .chipEnable, .pdLoad, .pdMainIn, .pdAuxIn,
		.mainDigLock(locks[3]), .auxDigLock(locks[2]), .mainAnaLock(locks[1]), .auxAnaLock(locks[0]),
		.auxRefDiv(divCnt[1]), .auxFbDiv(divCnt[2]), .mainRefDiv(divCnt[3]), .mainFbDiv(divCnt[4]),
		.refInputPin, .fracNumLow, .fracDenLow, .testLockOut, .testLockOe, .refOutPin, .refOutOe, .auxPrescaler16,
		.mainPumpPositive, .auxPumpPositive, .mainRefDoubler, .modulatorOrder, .modulatorBypass, .ditherWeak,
		.ditherStrong, .mainPowerdown, .auxPowerdown, .fracWide, .fracNumerator, .fracDenominator, .wordData,
		.wordAddr, .wordStrobe, .accessBits);

	always #10 clk_sys = ~clk_sys;
	// dividers run at four different rates so a swapped selection shows up
	always @(negedge clk_sys) divCnt <= divCnt + 8'h01;

	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic send(input logic [23:0] x);
		host.shift(x, $urandom_range(2));
		host.latch();
		chk(wordStrobe, 1'b1, "strobe");
		repeat (5) @(negedge clk_sys);
		chk(wordStrobe, 1'b0, "strobe end");
		chk(wordData, x, "word");
		chk(24'(wordAddr), 24'(x[3:0]), "addr");
	endtask : send
	// {dbl, refbuf, auxpol, mainpol, presc} travel together in b
	function automatic logic [23:0] loop_word(input logic au, input logic [1:0] di, input logic [1:0] fm,
		input logic [4:0] b, input logic [3:0] sel);
		return {au, 2'b01, 3'h0, di, fm, 1'b0, b, sel, `SCM_ADDR_LOOP};
	endfunction : loop_word
	task automatic check_loop(input logic [23:0] x);
		chk(auxPrescaler16, x[8], "presc");
		chk(mainPumpPositive, x[9], "mainpol");
		chk(auxPumpPositive, x[10], "auxpol");
		chk(refOutOe, x[11], "refoe");
		// a floated reference output carries no data, the buffer keeps it quiet
		chk(refOutPin, refInputPin & x[11], "refpin");
		chk(mainRefDoubler, x[12], "dbl");
		chk({modulatorBypass, modulatorOrder}, {x[15:14] == 2'h1, x[15:14]}, "order");
		chk({ditherStrong, ditherWeak}, {x[17:16] == 2'h2, x[17:16] == 2'h1}, "dither");
	endtask : check_loop
	// {oe, out} of the test pin for a select code and {mainDig, auxDig, mainAna, auxAna}
	function automatic logic [1:0] pin_exp(input logic [3:0] c, input logic [3:0] l);
		case (c)
			4'h0: return 2'b00;
			4'h1: return 2'b11;
			4'h2: return 2'b10;
			4'h3: return {1'b1, l[3] & l[2]};
			4'h4: return {1'b1, l[3]};
			4'h5: return {1'b1, l[2]};
			4'h6: return {~(l[1] & l[0]), 1'b0};
			4'h7: return {~l[1], 1'b0};
			4'h8: return {~l[0], 1'b0};
			4'h9: return {1'b1, l[1] & l[0]};
			4'ha: return {1'b1, l[1]};
			default: return {1'b1, l[0]};
		endcase
	endfunction : pin_exp
	task automatic pd_set(input logic m, input logic a);
		@(negedge clk_sys);
		{pdLoad, pdMainIn, pdAuxIn} = {1'b1, m, a};
		@(negedge clk_sys);
		pdLoad = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : pd_set

	// watchdog: the tests need well under 30000 cycles
	initial begin
		#600000;
		n_errors++;
		results();
	end

	initial begin
		{clk_sys, rst, chipEnable, pdLoad, pdMainIn, pdAuxIn, refInputPin} = 7'b0110000;
		{locks, divCnt, fracNumLow, fracDenLow, n_errors, check_count} = '0;
		void'($urandom(8));
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		check_loop(`SCM_RST_LOOP);
		chk({mainPowerdown, auxPowerdown, fracWide, testLockOe, accessBits}, 8'hc1, "reset misc");
		$display("test reset done");
		// every order and dither code, flag bits all clear, then random, all set last
		for (int i = 0; i < 16; i++) begin
			refInputPin = 1'($urandom);
			w = loop_word(1'b0, 2'(i), 2'(i >> 2), i == 0 ? 5'h00 : i == 15 ? 5'h1f : 5'($urandom), 4'h0);
			send(w);
			check_loop(w);
		end
		// settings must not move while a shifted word waits for its latch
		cur = w;
		w = loop_word(1'b0, ~cur[17:16], ~cur[15:14], 5'h04 | ~cur[12:8], 4'h0);
		host.shift(w, 1);
		repeat (3) @(negedge clk_sys);
		check_loop(cur);
		host.latch();
		repeat (5) @(negedge clk_sys);
		check_loop(w);
		$display("test loop fields done");
		// every select code, two lock patterns each, halved dividers by edge rate
		for (int c = 0; c < 16; c++) begin
			send(loop_word(1'b0, 2'h2, 2'h3, 5'h07, 4'(c)));
			for (int j = 0; j < 2; j++) begin
				locks = j == 0 ? 4'($urandom) : ~locks;
				repeat (3) @(negedge clk_sys);
				if (c < 12) chk({testLockOe, c == 0 ? 1'b0 : testLockOut}, pin_exp(4'(c), locks), "pin");
			end
			if (c >= 12) begin
				e = 32 >> (c - 11);
				n = 0;
				prev = testLockOut;
				repeat (128) begin
					@(negedge clk_sys);
					if (testLockOut === 1'b1 && prev === 1'b0) n++;
					prev = testLockOut;
				end
				chk({testLockOe, n >= e - 1 && n <= e + 1}, 2'b11, "halved");
			end
		end
		$display("test select done");
		// auto power-up on word zero, blocked by chip enable, off when bit clear
		send(loop_word(1'b1, 2'h2, 2'h3, 5'h07, 4'h0));
		pd_set(1'b1, 1'b0);
		chk({mainPowerdown, auxPowerdown}, 2'b10, "pd load");
		send({20'($urandom), 4'h3});
		chk({mainPowerdown, auxPowerdown}, 2'b10, "odd word");
		send({20'($urandom), 4'h0});
		chk({mainPowerdown, auxPowerdown}, 2'b00, "autopu");
		pd_set(1'b1, 1'b1);
		chipEnable = 1'b0;
		send({20'($urandom), 4'h0});
		chk({mainPowerdown, auxPowerdown}, 2'b11, "ce low");
		chipEnable = 1'b1;
		send(loop_word(1'b0, 2'h2, 2'h3, 5'h07, 4'h0));
		send({20'($urandom), 4'h0});
		chk({mainPowerdown, auxPowerdown}, 2'b11, "autopu off");
		$display("test power done");
		// narrow mode ignores the extended word, wide mode joins it
		{fracNumLow, fracDenLow} = 24'($urandom);
		send({20'($urandom), `SCM_ADDR_EXT});
		chk({fracWide, fracNumerator, fracDenominator},
			{1'b0, 10'h0, fracNumLow, 10'h0, fracDenLow}, "narrow");
		send({4'h3, 16'($urandom), `SCM_ADDR_ACCESS});
		chk({fracWide, accessBits}, 5'h13, "access");
		for (int j = 0; j < 2; j++) begin
			nu = j == 0 ? 10'h000 : 10'($urandom);
			du = 10'($urandom);
			send({du, nu, `SCM_ADDR_EXT});
			chk({fracNumerator, fracDenominator}, {nu, fracNumLow, du, fracDenLow}, "wide");
		end
		send({4'h1, 16'($urandom), `SCM_ADDR_ACCESS});
		send({4'h3, 16'($urandom), `SCM_ADDR_ACCESS});
		chk({fracNumerator, fracDenominator}, {10'h0, fracNumLow, 10'h0, fracDenLow}, "default");
		$display("test fraction done");
		results();
	end
endmodule : tb
`default_nettype wire
